// File: verilog/rsse_pkg.sv
// Shared constants and types of the rotate / fill / sleep execution block.
// Assumes a single core clock and an 8-bit data path with 12-bit data addresses.
package rsse_pkg;

    // ------------------------------------------------------------------
    // Register bus map
    // ------------------------------------------------------------------
    localparam int         BUS_AW    = 4;
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_BANK  = 4'h1;
    localparam logic [3:0] OFS_WREG  = 4'h2;
    localparam logic [3:0] OFS_STAT  = 4'h3;
    localparam logic [3:0] OFS_IDXL  = 4'h4;
    localparam logic [3:0] OFS_IDXH  = 4'h5;
    localparam logic [3:0] OFS_MADL  = 4'h6;
    localparam logic [3:0] OFS_MADH  = 4'h7;
    localparam logic [3:0] OFS_MDAT  = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_EXT  = 0;
    localparam int STAT_NEG  = 0;
    localparam int STAT_ZERO = 1;
    localparam int STAT_PWRD = 2;
    localparam int STAT_WDOG = 3;
    localparam int STAT_SLP  = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_BANK   = 4'h0;
    localparam logic [7:0] RST_WREG   = 8'h00;
    localparam logic       RST_PWRD_N = 1'b1;
    localparam logic       RST_WDOG_N = 1'b1;

    // ------------------------------------------------------------------
    // Encodings and constants
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_ROT   = 6'h10;
    localparam logic [6:0] OPC_FILL  = 7'h34;
    localparam logic [7:0] ACC_SPLIT = 8'h5f;
    localparam logic [3:0] ACC_LOW   = 4'h0;
    localparam logic [3:0] ACC_HIGH  = 4'hf;
    localparam logic [7:0] FILL_VAL  = 8'hff;
    localparam int         PHASES    = 4;

    typedef enum logic [1:0] {OP_NONE, OP_ROT, OP_FILL, OP_SLP} rsse_op_t;
    typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_SLEEP} rsse_st_t;

endpackage

// File: verilog/rsse_fmem.sv
// Data memory of the core: two ports, registered read data on both.
// Assumes port a (core) and port b (software) share the clock; a wins a write clash.
`timescale 1ns/1ps
`default_nettype none

module rsse_fmem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic          ref_clk,
    input  wire logic [AW-1:0] a_addr,
    input  wire logic          a_we,
    input  wire logic [DW-1:0] a_wdata,
    output logic      [DW-1:0] a_rdata,
    input  wire logic [AW-1:0] b_addr,
    input  wire logic          b_we,
    input  wire logic [DW-1:0] b_wdata,
    output logic      [DW-1:0] b_rdata
);

    typedef struct packed {
        logic [DW-1:0] ra;
        logic [DW-1:0] rb;
    } rsse_fmem_t;

    logic [DW-1:0] mem [2**AW];
    rsse_fmem_t    q;

    if (AW < 1 || AW > 16 || DW < 1) begin : g_bad_size
        $error("rsse_fmem: unsupported size");
    end

    always_ff @(posedge ref_clk) begin
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        q <= '{ra: mem[a_addr], rb: mem[b_addr]};
    end

    assign a_rdata = q.ra;
    assign b_rdata = q.rb;

endmodule

`default_nettype wire

// File: verilog/rsse_alu.sv
// Data stage of the block: rotate right without carry, or all ones.
// Assumes the operand is the value read from the addressed file register.
`timescale 1ns/1ps
`default_nettype none

module rsse_alu
    import rsse_pkg::*;
(
    input  wire rsse_op_t   op,
    input  wire logic [7:0] opnd,
    output logic      [7:0] res,
    output logic            neg,
    output logic            zero
);

    function automatic logic [7:0] rot_right(input logic [7:0] v);
        return {v[0], v[7:1]};
    endfunction

    always_comb begin
        unique case (op)
            OP_ROT:  res = rot_right(opnd);
            OP_FILL: res = FILL_VAL;
            default: res = opnd;
        endcase
        neg  = res[7];
        zero = (res == 8'h00);
    end

endmodule

`default_nettype wire

// File: verilog/rsse_core.sv
// Execution unit for rotate right, fill with ones and sleep, with its registers.
// Assumes instruction words arrive from the fetch path on ref_clk and that the
// watchdog and wake logic sit on the same clock.
//
// What this block does
// RL1 - Rotate right moves bit n of the operand to bit n-1 and bit 0 to bit 7, and sets N and Z from the result.
// RL2 - Rotate right is decoded as 0100 00, destination bit, bank access bit, eight-bit file address.
// RL3 - Destination bit 0 sends the result to W and leaves the file register alone; 1 writes it back.
// RL4 - Bank access bit 0 selects the access bank whatever the bank pointer holds; 1 uses the bank pointer.
// RL5 - With the extended set on, access bit 0 and address up to 95, the operand is indexed from a base.
// RL6 - Each instruction is one word executed in four phases: decode, read, process, write or sleep.
// RL7 - Fill writes FFh into the addressed register with the same bank selection and leaves flags alone.
// RL8 - Sleep clears the power-down flag to zero.
// RL9 - Sleep sets the watchdog time-out flag to one.
// RL10 - Sleep clears the watchdog counter and its postscaler.
// RL11 - After sleep the core halts with its oscillator stopped, entered in the last phase.
// RL12 - A wake caused by the watchdog clears the time-out flag that sleep had set.
`timescale 1ns/1ps
`default_nettype none

module rsse_core
    import rsse_pkg::*;
#(
    parameter logic [15:0] SLEEP_CODE = 16'h0003
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    input  wire logic        wake_dog,
    input  wire logic        wake_event,
    input  wire logic [3:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic             instr_ready,
    output logic [7:0]       bus_rdata,
    output logic             sleep_mode,
    output logic             osc_stop,
    output logic             watchdog_counter_clr,
    output logic             postscaler_clr,
    output logic             op_done
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        rsse_st_t    st;
        rsse_op_t    op;
        logic [15:0] iw;
        logic        dst;
        logic [11:0] fa;
        logic [7:0]  res;
        logic        rneg;
        logic        rzero;
        logic [7:0]  w;
        logic        neg;
        logic        zero;
        logic        sleep_entered_flag_n;
        logic        dog_expired_flag_n;
        logic [3:0]  bank_pointer_reg;
        logic        ext;
        logic [11:0] idx;
        logic [11:0] madr;
        logic [7:0]  rdata;
        logic        rdy;
        logic        slp;
        logic        wclr;
        logic        done;
    } rsse_core_t;

    rsse_core_t q;
    rsse_core_t d;

    logic [7:0] mem_rdata;
    logic [7:0] mem_b_rdata;
    logic       mem_we;
    logic       mem_b_we;
    logic [7:0] alu_res;
    logic       alu_neg;
    logic       alu_zero;

    // A sleep word that aliases another opcode could never be reached
    if (SLEEP_CODE[15:10] == OPC_ROT || SLEEP_CODE[15:9] == OPC_FILL) begin : g_bad_code
        $error("rsse_core: sleep code collides with another opcode");
    end

    // ------------------------------------------------------------------
    // Decode and address helpers
    // ------------------------------------------------------------------
    function automatic rsse_op_t decode(input logic [15:0] w);
        if (w[15:10] == OPC_ROT) begin
            return OP_ROT;                                       // [RL2]
        end else if (w[15:9] == OPC_FILL) begin
            return OP_FILL;
        end else if (w == SLEEP_CODE) begin
            return OP_SLP;
        end
        return OP_NONE;
    endfunction

    function automatic logic [11:0] addr_calc(input logic        a,
                                              input logic [7:0]  f,
                                              input logic [3:0]  bank,
                                              input logic        ext,
                                              input logic [11:0] idx);
        if (a) begin
            return {bank, f};                                    // [RL4]
        end else if (ext && f <= ACC_SPLIT) begin
            return 12'(idx + {4'h0, f});                         // [RL5]
        end else if (f <= ACC_SPLIT) begin
            return {ACC_LOW, f};                                 // [RL4]
        end
        return {ACC_HIGH, f};
    endfunction

    function automatic logic [7:0] read_mux(input logic [3:0] a, input rsse_core_t s, input logic [7:0] md);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            OFS_CTRL: r[CTRL_EXT] = s.ext;
            OFS_BANK: r = {4'h0, s.bank_pointer_reg};
            OFS_WREG: r = s.w;
            OFS_STAT: begin
                r[STAT_NEG]  = s.neg;
                r[STAT_ZERO] = s.zero;
                r[STAT_PWRD] = s.sleep_entered_flag_n;
                r[STAT_WDOG] = s.dog_expired_flag_n;
                r[STAT_SLP]  = s.slp;
            end
            OFS_IDXL: r = s.idx[7:0];
            OFS_IDXH: r = {4'h0, s.idx[11:8]};
            OFS_MADL: r = s.madr[7:0];
            OFS_MADH: r = {4'h0, s.madr[11:8]};
            OFS_MDAT: r = md;
            default:  r = 8'h00;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    rsse_alu u_alu (
        .op   (q.op),
        .opnd (mem_rdata),
        .res  (alu_res),
        .neg  (alu_neg),
        .zero (alu_zero)
    );

    // Write phase stores to the file register only when the result goes there
    assign mem_we   = (q.st == ST_Q4) && ((q.op == OP_ROT && q.dst) || q.op == OP_FILL);   // [RL3] [RL7]
    assign mem_b_we = bus_wr && (bus_addr == OFS_MDAT);

    rsse_fmem #(
        .AW (12),
        .DW (8)
    ) u_fmem (
        .ref_clk (ref_clk),
        .a_addr  (q.fa),
        .a_we    (mem_we),
        .a_wdata (q.res),
        .a_rdata (mem_rdata),
        .b_addr  (q.madr),
        .b_we    (mem_b_we),
        .b_wdata (bus_wdata),
        .b_rdata (mem_b_rdata)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        d.wclr  = 1'b0;
        d.done  = 1'b0;
        d.rdata = 8'h00;

        // Software writes first so that a core write in the same cycle wins
        if (bus_wr) begin
            unique case (bus_addr)
                OFS_CTRL: d.ext = bus_wdata[CTRL_EXT];
                OFS_BANK: d.bank_pointer_reg = bus_wdata[3:0];
                OFS_WREG: d.w = bus_wdata;
                OFS_IDXL: d.idx[7:0] = bus_wdata;
                OFS_IDXH: d.idx[11:8] = bus_wdata[3:0];
                OFS_MADL: d.madr[7:0] = bus_wdata;
                OFS_MADH: d.madr[11:8] = bus_wdata[3:0];
                default: ;
            endcase
        end
        if (bus_rd) begin
            d.rdata = read_mux(bus_addr, q, mem_b_rdata);
        end

        unique case (q.st)
            ST_IDLE: begin
                if (instr_valid) begin
                    d.iw  = instr_word;
                    d.rdy = 1'b0;
                    d.st  = ST_Q1;                               // [RL6]
                end
            end
            ST_Q1: begin
                d.op  = decode(q.iw);                            // [RL2]
                d.dst = q.iw[9];
                d.fa  = addr_calc(q.iw[8], q.iw[7:0], q.bank_pointer_reg, q.ext, q.idx);   // [RL4] [RL5]
                d.st  = ST_Q2;
            end
            ST_Q2: begin
                d.st = ST_Q3;
            end
            ST_Q3: begin
                d.res   = alu_res;                               // [RL1]
                d.rneg  = alu_neg;
                d.rzero = alu_zero;
                d.st    = ST_Q4;
            end
            ST_Q4: begin
                d.done = 1'b1;
                d.st   = ST_IDLE;
                d.rdy  = 1'b1;
                unique case (q.op)
                    OP_ROT: begin
                        if (!q.dst) begin
                            d.w = q.res;                         // [RL3]
                        end
                        d.neg  = q.rneg;                         // [RL1]
                        d.zero = q.rzero;
                    end
                    OP_SLP: begin
                        d.sleep_entered_flag_n = 1'b0;           // [RL8]
                        d.dog_expired_flag_n   = 1'b1;           // [RL9]
                        d.wclr                 = 1'b1;           // [RL10]
                        d.slp                  = 1'b1;           // [RL11]
                        d.rdy                  = 1'b0;
                        d.st                   = ST_SLEEP;
                    end
                    default: ;
                endcase
            end
            ST_SLEEP: begin
                if (wake_dog || wake_event) begin
                    d.slp = 1'b0;
                    d.rdy = 1'b1;
                    d.st  = ST_IDLE;
                    if (wake_dog) begin
                        d.dog_expired_flag_n = 1'b0;             // [RL12]
                    end
                end
            end
            default: begin
                d.st  = ST_IDLE;
                d.rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q                      <= '0;
            q.st                   <= ST_IDLE;
            q.op                   <= OP_NONE;
            q.w                    <= RST_WREG;
            q.bank_pointer_reg     <= RST_BANK;
            q.sleep_entered_flag_n <= RST_PWRD_N;
            q.dog_expired_flag_n   <= RST_WDOG_N;
            q.rdy                  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign instr_ready          = q.rdy;
    assign bus_rdata            = q.rdata;
    assign sleep_mode           = q.slp;
    assign osc_stop             = q.slp;
    assign watchdog_counter_clr = q.wclr;
    assign postscaler_clr       = q.wclr;
    assign op_done              = q.done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic [7:0] opnd_seen;
    always_ff @(posedge ref_clk) begin
        if (q.st == ST_Q3) begin
            opnd_seen <= mem_rdata;
        end
    end

    a_rot_value: assert property ((q.st == ST_Q4 && q.op == OP_ROT)      // [RL1]
        |-> q.res == {opnd_seen[0], opnd_seen[7:1]})
        else $error("rotate result wrong");

    a_rot_flags: assert property ((q.st == ST_Q4 && q.op == OP_ROT)      // [RL1]
        |=> (q.neg == $past(q.res[7])) && (q.zero == ($past(q.res) == 8'h00)))
        else $error("rotate flags wrong");

    a_rot_decode: assert property ((q.st == ST_Q1 && q.iw[15:10] == 6'h10)   // [RL2]
        |=> q.op == OP_ROT && q.dst == $past(q.iw[9]))
        else $error("rotate not decoded");

    a_dest_sel: assert property ((q.st == ST_Q4 && q.op == OP_ROT && !q.dst)   // [RL3]
        |-> !mem_we ##1 q.w == $past(q.res))
        else $error("destination select wrong");

    a_bank_sel: assert property ((q.st == ST_Q1 && q.iw[8])              // [RL4]
        |=> q.fa[11:8] == $past(q.bank_pointer_reg))
        else $error("bank pointer not used");

    a_index_mode: assert property ((q.st == ST_Q1 && !q.iw[8] && q.ext && q.iw[7:0] <= 8'h5f)   // [RL5]
        |=> q.fa == 12'($past(q.idx) + {4'h0, $past(q.iw[7:0])}))
        else $error("indexed address wrong");

    a_four_phase: assert property ((q.st == ST_IDLE && instr_valid)      // [RL6]
        |=> q.st == ST_Q1 ##1 q.st == ST_Q2 ##1 q.st == ST_Q3 ##1 q.st == ST_Q4)
        else $error("phase sequence broken");

    a_fill_ones: assert property ((q.st == ST_Q4 && q.op == OP_FILL)     // [RL7]
        |-> mem_we && q.res == 8'hff ##1 $stable(q.neg) && $stable(q.zero))
        else $error("fill wrong");

    a_sleep_entry: assert property ((q.st == ST_Q4 && q.op == OP_SLP)    // [RL8] [RL9] [RL10] [RL11]
        |=> !q.sleep_entered_flag_n && q.dog_expired_flag_n && watchdog_counter_clr
            && postscaler_clr && osc_stop && !instr_ready)
        else $error("sleep entry wrong");

    a_sleep_hold: assert property ((sleep_mode && !wake_dog && !wake_event)   // [RL11]
        |=> sleep_mode && osc_stop)
        else $error("left sleep without wake");

    a_dog_wake: assert property ((sleep_mode && wake_dog)                // [RL12]
        |=> !q.dog_expired_flag_n && !sleep_mode)
        else $error("watchdog wake flag wrong");

    c_rot_to_w:  cover property (q.st == ST_Q4 && q.op == OP_ROT && !q.dst);
    c_rot_to_f:  cover property (q.st == ST_Q4 && q.op == OP_ROT && q.dst);
    c_fill:      cover property (q.st == ST_Q4 && q.op == OP_FILL);
    c_dog_wake:  cover property (sleep_mode && wake_dog);
    c_sleep_in:  cover property (q.st == ST_Q4 && q.op == OP_SLP);

endmodule

`default_nettype wire

// File: tb/rsse_core_tb.sv
// Self-checking bench of the rotate / fill / sleep execution unit.
// Assumes rsse_pkg and the design files are compiled first; one clock, 250 MHz.
`timescale 1ns/1ps
`default_nettype none

module rsse_core_tb
    import rsse_pkg::*;
;
    typedef struct {string name; logic [7:0] val;} rsse_note_t;

    localparam logic [15:0] SLP_WORD = 16'h0003;

    logic        ref_clk;
    logic        sys_rst;
    logic [15:0] instr_word;
    logic        instr_valid;
    logic        wake_dog;
    logic        wake_event;
    logic [3:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic        instr_ready;
    logic [7:0]  bus_rdata;
    logic        sleep_mode;
    logic        osc_stop;
    logic        watchdog_counter_clr;
    logic        postscaler_clr;
    logic        op_done;
    logic        rd_seen;
    rsse_note_t  notes[$];
    rsse_note_t  note;
    int          miscompares;
    int          n_checks;
    logic        nf, zf, pwrd_e, wdog_e, slp_e;
    logic [7:0]  wexp;

    rsse_core #(.SLEEP_CODE(SLP_WORD)) u_rsse_core (
        .ref_clk              (ref_clk),
        .sys_rst              (sys_rst),
        .instr_word           (instr_word),
        .instr_valid          (instr_valid),
        .wake_dog             (wake_dog),
        .wake_event           (wake_event),
        .bus_addr             (bus_addr),
        .bus_wdata            (bus_wdata),
        .bus_wr               (bus_wr),
        .bus_rd               (bus_rd),
        .instr_ready          (instr_ready),
        .bus_rdata            (bus_rdata),
        .sleep_mode           (sleep_mode),
        .osc_stop             (osc_stop),
        .watchdog_counter_clr (watchdog_counter_clr),
        .postscaler_clr       (postscaler_clr),
        .op_done              (op_done)
    );

    // ------------------------------------------------------------------
    // Clock, comparison and verdict
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] ev);
        n_checks++;
        if (seen !== ev) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, ev, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) rd_seen <= bus_rd;

    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            if (notes.size() == 0) begin
                miscompares++;
                $display("BAD read_note expected queued seen none");
            end else begin
                note = notes.pop_front();
                check(note.name, bus_rdata, note.val);
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus and instruction drivers
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge ref_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= ad;
        bus_wdata <= dt;
        @(posedge ref_clk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [7:0] ev, input string nm);
        @(posedge ref_clk);
        bus_rd   <= 1'b1;
        bus_addr <= ad;
        notes.push_back('{nm, ev});
        @(posedge ref_clk);
        bus_rd   <= 1'b0;
    endtask

    task automatic set_madr(input logic [11:0] ad);
        wr(OFS_MADL, ad[7:0]);
        wr(OFS_MADH, {4'h0, ad[11:8]});
    endtask

    task automatic chk_mem(input logic [11:0] ad, input logic [7:0] ev, input string nm);
        set_madr(ad);
        repeat (2) @(posedge ref_clk);
        rd(OFS_MDAT, ev, nm);
    endtask

    function automatic logic [7:0] stat();
        return {3'b000, slp_e, wdog_e, pwrd_e, zf, nf};
    endfunction

    function automatic logic [11:0] addr_of(input logic a, input logic [7:0] f, input logic [3:0] b,
                                            input logic e, input logic [11:0] ix);
        if (a)
            return {b, f};
        if (f <= 8'h5f)
            return e ? ix + {4'h0, f} : {4'h0, f};
        return {4'hf, f};
    endfunction

    task automatic exec(input logic [15:0] w, input logic slp);
        int n;
        n = 0;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        n = 1;
        check("busy", {7'h0, instr_ready}, 8'h00);
        while (op_done !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check("done_latency", 8'(n), 8'(PHASES + 1));
        if (slp) begin
            check("sleep_osc", {6'h0, sleep_mode, osc_stop}, 8'h03);
            check("clr_pulse", {6'h0, watchdog_counter_clr, postscaler_clr}, 8'h03);
            check("halt_ready", {7'h0, instr_ready}, 8'h00);
            @(negedge ref_clk);
            check("clr_once", {6'h0, watchdog_counter_clr, postscaler_clr}, 8'h00);
            check("still_asleep", {7'h0, sleep_mode}, 8'h01);
        end
    endtask

    task automatic wake(input logic dog);
        @(posedge ref_clk);
        wake_dog   <= dog;
        wake_event <= ~dog;
        @(posedge ref_clk);
        wake_dog   <= 1'b0;
        wake_event <= 1'b0;
        @(negedge ref_clk);
        check("woken", {6'h0, sleep_mode, instr_ready}, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end

    initial begin
        logic [7:0]  v, f, rot;
        logic [3:0]  bank;
        logic [11:0] idx, ad;
        logic        a, d, ext;
        sys_rst = 1'b1; instr_word = 16'h0000; instr_valid = 1'b0; wake_dog = 1'b0;
        wake_event = 1'b0; bus_addr = 4'h0; bus_wdata = 8'h00; bus_wr = 1'b0; bus_rd = 1'b0;
        rd_seen = 1'b0; miscompares = 0; n_checks = 0;
        nf = 1'b0;
        zf = 1'b0;
        pwrd_e = 1'b1;
        wdog_e = 1'b1;
        slp_e = 1'b0;
        wexp = 8'h00;
        void'($urandom(32'h013f));
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;

        rd(OFS_STAT, stat(), "status_reset");
        rd(OFS_WREG, 8'h00, "w_reset");
        wr(OFS_STAT, 8'hff);
        rd(OFS_STAT, stat(), "status_readonly");
        rd(4'h9, 8'h00, "unmapped");
        $display("test reset done");

        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hd7 : 8'($urandom);
            bank = 4'($urandom);
            idx  = 12'($urandom);
            a    = (i % 4 == 0);
            d    = (i % 4 != 1) && (i != 7);
            ext  = (i % 4 == 3);
            case (i % 4)
                0: f = 8'($urandom);
                1: f = (i == 1) ? 8'h60 : 8'h60 + 8'($urandom % 160);
                default: f = (i == 2) ? 8'h5f : 8'($urandom % 96);
            endcase
            wr(OFS_BANK, {4'h0, bank});
            wr(OFS_CTRL, {7'h00, ext});
            wr(OFS_IDXL, idx[7:0]);
            wr(OFS_IDXH, {4'h0, idx[11:8]});
            ad = addr_of(a, f, bank, ext, idx);
            set_madr(ad);
            wr(OFS_MDAT, v);
            exec({OPC_ROT, d, a, f}, 1'b0);
            rot = {v[0], v[7:1]};
            nf  = rot[7];
            zf  = (rot == 8'h00);
            if (d) begin
                chk_mem(ad, rot, "rot_mem");
            end else begin
                wexp = rot;
                rd(OFS_WREG, wexp, "rot_w");
                chk_mem(ad, v, "mem_kept");
            end
            rd(OFS_STAT, stat(), "rot_flags");
        end
        $display("test rotate done");

        wr(OFS_CTRL, 8'h00);
        for (int j = 0; j < 2; j++) begin
            a    = j[0];
            bank = 4'($urandom);
            f    = a ? 8'($urandom) : 8'h60 + 8'($urandom % 160);
            wr(OFS_BANK, {4'h0, bank});
            ad = addr_of(a, f, bank, 1'b0, 12'h000);
            set_madr(ad);
            wr(OFS_MDAT, 8'($urandom));
            exec({OPC_FILL, a, f}, 1'b0);
            chk_mem(ad, FILL_VAL, "fill_mem");
            rd(OFS_STAT, stat(), "fill_flags");
        end
        $display("test fill done");

        // A word that is none of the three must leave W and the flags alone
        exec(16'h1234, 1'b0);
        rd(OFS_WREG, wexp, "nop_w");
        rd(OFS_STAT, stat(), "nop_flags");
        $display("test unknown word done");

        exec(SLP_WORD, 1'b1);
        pwrd_e = 1'b0;
        wdog_e = 1'b1;
        slp_e = 1'b1;
        rd(OFS_STAT, stat(), "sleep_status");
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_word  <= {OPC_ROT, 2'b00, 8'h70};
        repeat (3) @(negedge ref_clk);
        check("asleep_ready", {7'h0, instr_ready}, 8'h00);
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        wake(1'b1);
        wdog_e = 1'b0;
        slp_e = 1'b0;
        rd(OFS_STAT, stat(), "dog_wake_status");
        rd(OFS_WREG, wexp, "w_untouched");
        exec(SLP_WORD, 1'b1);
        wdog_e = 1'b1;
        slp_e = 1'b1;
        rd(OFS_STAT, stat(), "sleep_again");
        wake(1'b0);
        slp_e = 1'b0;
        rd(OFS_STAT, stat(), "event_wake_status");
        repeat (3) @(posedge ref_clk);
        $display("test sleep done");
        final_report();
    end

endmodule

`default_nettype wire
